// *** bench/high_rate_psdu_mode_tb.sv ***
// Self-checking bench for the high rate payload mode controller
`timescale 1ns/1ps
module high_rate_psdu_mode_tb;
    // ==========================================
    // Signals and bench state
    localparam int ED_S = 8;
    localparam int ED_L = 16;
    localparam int ACK_L = 24;
    localparam int ACK_S = 4;
    logic i_clk = 0, i_nrst = 0, i_ce = 1, i_reg_wr = 0, i_reg_rd = 0;
    logic [7:0] i_reg_addr = 8'h00, i_reg_wdata = 8'h00;
    logic i_fb_start = 0, i_fb_next = 0, i_ed_start = 0;
    logic i_auto_ack_receive_mode = 0, i_ack_frame_end = 0;
    logic [7:0] i_radio_state_byte = 8'h00, i_frame_len = 8'h00;
    logic [7:0] i_ed_value = 8'h00, i_rx_status = 8'h00;
    logic [1:0] i_cca_mode_req = 2'h0;
    wire i_rx_hdr_det, i_rx_payload_ok, i_rx_end, i_rx_byte_valid;
    wire [7:0] i_rx_rssi_step, i_rx_byte, o_reg_rdata, o_fb_data;
    wire o_rx_byte_ready, o_fb_valid, o_hdr_rate_std, o_scramble_on;
    wire o_frame_reject, o_frame_accept, o_rx_protect, o_ed_busy;
    wire o_ed_done, o_ack_tx_start;
    wire [2:0] o_payload_rate;
    wire [1:0] o_cca_mode;
    int fail_count = 0, total_checks = 0, cyc = 0, n_acc = 0, n_rej = 0;
    int regs[int];
    logic [7:0] q[$];
    // Design with short windows, far-side node
    hrpm_core #(
        .ED_SHORT_CYC(ED_S),
        .ED_STD_CYC(ED_L),
        .ACK_STD_CYC(ACK_L),
        .ACK_SHORT_CYC(ACK_S)
    ) i_hrpm_core (.*);
    hrpm_air i_hrpm_air (
        .i_clk(i_clk),
        .i_ready(o_rx_byte_ready),
        .o_valid(i_rx_byte_valid),
        .o_byte(i_rx_byte),
        .o_hdr(i_rx_hdr_det),
        .o_ok(i_rx_payload_ok),
        .o_end(i_rx_end),
        .o_rssi(i_rx_rssi_step)
    );
    // 25 MHz clock
    always #20 i_clk = ~i_clk;
    // Verdict pulse counters and hang guard
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (o_frame_accept === 1'b1) n_acc <= n_acc + 1;
        if (o_frame_reject === 1'b1) n_rej <= n_rej + 1;
        if (cyc == 20000) begin
            fail_count++;
            conclude();
        end
    end
    // ==========================================
    // Model and bus tasks
    function automatic int mask_of(input int a);
        return a == 8'h0C ? 8'hA7 : a == 8'h15 ? 8'h8F :
            a == 8'h17 ? 8'hF7 : 0;
    endfunction
    task chk_byte(input string n, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH %s exp %h got %h", n, e, g);
        end
    endtask
    task chk_cnt(input string n, input int e, input int g);
        total_checks++;
        if (g != e) begin
            fail_count++;
            $display("MISMATCH %s exp %0d got %0d", n, e, g);
        end
    endtask
    task wreg(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_reg_wr <= 1;
        i_reg_addr <= a;
        i_reg_wdata <= d;
        @(posedge i_clk);
        i_reg_wr <= 0;
        if (mask_of(a) != 0) regs[a] = d & mask_of(a);
    endtask
    task cmp_reg(input logic [7:0] a);
        @(posedge i_clk);
        i_reg_rd <= 1;
        i_reg_addr <= a;
        @(posedge i_clk);
        i_reg_rd <= 0;
        @(posedge i_clk);
        #1;
        chk_byte("reg", regs.exists(a) ? 8'(regs[a]) : 8'h00, o_reg_rdata);
    endtask
    task fb_step(input logic s, input string n, input logic [7:0] e);
        @(posedge i_clk);
        i_fb_start <= s;
        i_fb_next <= !s;
        @(posedge i_clk);
        i_fb_start <= 0;
        i_fb_next <= 0;
        @(posedge i_clk);
        #1;
        chk_byte(n, e, o_fb_data);
        chk_byte("fb_valid", 8'h01, 8'(o_fb_valid));
    endtask
    // Cycles from a trigger to energy done (0) or ack start (1)
    task tmeas(input int k, output int n);
        @(posedge i_clk);
        if (k == 0) i_ed_start <= 1;
        else i_ack_frame_end <= 1;
        @(posedge i_clk);
        i_ed_start <= 0;
        i_ack_frame_end <= 0;
        n = 0;
        #1;
        while ((k == 0 ? o_ed_done : o_ack_tx_start) !== 1'b1 && n < 100) begin
            @(posedge i_clk);
            #1;
            n++;
        end
    endtask
    task conclude;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // ==========================================
    // Test sequence
    initial begin
        int n0, n, lvl, rt, rs, ok, rej, e;
        logic [7:0] v, st, e8, s8;
        void'($urandom(76960));
        regs[8'h0C] = 8'h20;
        repeat (8) @(posedge i_clk);
        i_nrst <= 1;
        repeat (3) @(posedge i_clk);
        // Reset values, write masks, unmapped place
        for (int i = 0; i < 4; i++) begin
            v = i == 0 ? 8'h0C : i == 1 ? 8'h15 : i == 2 ? 8'h17 : 8'h40;
            cmp_reg(v);
            wreg(v, 8'hFF);
            cmp_reg(v);
        end
        $display("test registers done");
        // Every rate code with random protect and scrambler bits
        for (int i = 0; i < 16; i++) begin
            rt = i % 8;
            v = 8'($urandom & 32'h0000_00A0) | 8'(rt);
            @(posedge i_clk);
            i_cca_mode_req <= 2'($urandom);
            wreg(8'h0C, v);
            repeat (3) @(posedge i_clk);
            #1;
            e = (rt > 0 && rt < 4) ? 1 : i_cca_mode_req;
            chk_byte("rate", rt < 4 ? 8'(rt) : 8'h00,
                8'(o_payload_rate));
            chk_byte("scram", 8'(rt == 3 && v[5]), 8'(o_scramble_on));
            chk_byte("cca", 8'(e), 8'(o_cca_mode));
            chk_byte("protect", 8'(v[7]), 8'(o_rx_protect));
            chk_byte("hdr_std", 8'h01, 8'(o_hdr_rate_std));
        end
        $display("test rates done");
        // Energy window shorter at every high rate
        wreg(8'h0C, 8'h20);
        tmeas(0, n0);
        for (int r = 1; r < 4; r++) begin
            wreg(8'h0C, 8'(32'h0000_0020 | r));
            tmeas(0, n);
            chk_cnt("ed_cycles", n0 - (ED_L - ED_S), n);
        end
        $display("test energy done");
        // Ack turnaround, long and short, then mode off
        wreg(8'h17, 8'h00);
        i_auto_ack_receive_mode <= 1;
        tmeas(1, n0);
        wreg(8'h17, 8'h04);
        tmeas(1, n);
        chk_cnt("ack_gap", ACK_L - ACK_S, n0 - n);
        @(posedge i_clk);
        i_auto_ack_receive_mode <= 0;
        tmeas(1, n);
        chk_cnt("ack_off", 100, n);
        $display("test ack done");
        // Threshold gating and weak payload rejection
        for (int i = 0; i < 14; i++) begin
            lvl = i < 5 ? 0 : $urandom % 16;
            rt = $urandom % 4;
            rs = $urandom % 16;
            ok = $urandom % 2;
            wreg(8'h15, 8'(lvl));
            wreg(8'h0C, 8'(32'h0000_0020 | rt));
            n0 = n_acc;
            n = n_rej;
            i_hrpm_air.frame(8'(rs), ok[0]);
            rej = (lvl != 0 && rs < lvl) || (rt != 0 && ok == 0);
            chk_byte("reject", 8'(rej),
                8'(n_rej - n));
            chk_byte("accept", 8'(!rej),
                8'(n_acc - n0));
        end
        $display("test receive done");
        // Buffer read at top rate; fill until refused, then drain
        wreg(8'h15, 8'h01);
        wreg(8'h0C, 8'h23);
        st = 8'($urandom);
        e8 = 8'($urandom);
        s8 = 8'($urandom);
        i_radio_state_byte <= st;
        i_frame_len <= 8'h08;
        i_ed_value <= e8;
        i_rx_status <= s8;
        fb_step(1, "state", st);
        for (int i = 0; i < 8; i++) begin
            q.push_back(8'($urandom));
            i_hrpm_air.push(q[i]);
        end
        repeat (2) @(posedge i_clk);
        #1;
        chk_byte("ready", 8'h00, 8'(o_rx_byte_ready));
        fb_step(0, "len", 8'h08);
        while (q.size() > 0) fb_step(0, "payload", q.pop_front());
        fb_step(0, "lqi", 8'h00);
        fb_step(0, "ed", e8);
        fb_step(0, "status", s8);
        $display("test buffer done");
        conclude();
    end
endmodule

// *** bench/hrpm_air.sv ***
// Behavioural far-side radio node feeding the receive pins
`timescale 1ns/1ps
module hrpm_air (
    // Clock
    input wire i_clk,
    // Octet stream handshake
    input wire i_ready,
    output logic o_valid,
    output logic [7:0] o_byte,
    // Demodulator pins
    output logic o_hdr,
    output logic o_ok,
    output logic o_end,
    output logic [7:0] o_rssi
);
    // ==========================================
    // Idle levels at time zero
    initial begin
        o_valid = 0;
        o_byte = 8'h00;
        o_hdr = 0;
        o_ok = 0;
        o_end = 0;
        o_rssi = 8'h00;
    end
    // One frame; sender preset to the receiver's rate
    task frame(input logic [7:0] rssi, input logic ok);
        @(posedge i_clk);
        o_rssi <= rssi;
        o_ok <= ok;
        repeat (3) @(posedge i_clk);
        o_hdr <= 1;
        repeat (10) @(posedge i_clk);
        o_hdr <= 0;
        o_end <= 1;
        repeat (4) @(posedge i_clk);
        o_end <= 0;
        o_ok <= ~ok;  // Released lines must not look valid
        o_rssi <= ~rssi;
        repeat (2) @(posedge i_clk);
    endtask
    // Octet push, held until ready
    task push(input logic [7:0] b);
        @(posedge i_clk);
        o_valid <= 1;
        o_byte <= b;
        do @(negedge i_clk); while (i_ready !== 1'b1);
        @(posedge i_clk);
        o_valid <= 0;
        o_byte <= ~b;
    endtask
endmodule

// *** bench/hrpm_core_props.sv ***
// Checker of the rate control, receive and timing outputs
`timescale 1ns/1ps
module hrpm_core_chk (
    // Clock and reset
    input wire i_clk,
    input wire i_nrst,
    // Register port
    input wire i_ce,
    input wire i_reg_wr,
    input wire i_reg_rd,
    input wire [7:0] i_reg_addr,
    input wire [7:0] i_reg_wdata,
    input wire [7:0] o_reg_rdata,
    // Modem control
    input wire [2:0] o_payload_rate,
    input wire o_hdr_rate_std,
    input wire o_scramble_on,
    input wire o_frame_reject,
    input wire o_frame_accept,
    input wire o_rx_protect,
    input wire [1:0] o_cca_mode,
    // Timing
    input wire o_ed_busy,
    input wire o_ed_done,
    input wire i_auto_ack_receive_mode,
    input wire i_ack_frame_end,
    input wire o_ack_tx_start
);
    // ==========================================
    // Assertions on the design's outputs, tag per label
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_nrst);
    rsvd_zero_a: assert property (i_ce && i_reg_rd &&
        i_reg_addr == 8'h0C |=> (o_reg_rdata & 8'h58) == 8'h00)
        else $error("reserved rate bits read set");
    hdr_std_a: assert property (o_hdr_rate_std)
        else $error("header rate not standard");
    protect_wr_a: assert property ((i_ce && i_reg_wr &&
        i_reg_addr == 8'h0C) ##1 !i_reg_wr
        |=> o_rx_protect == $past(i_reg_wdata[7], 2))
        else $error("protect bit not applied");
    rate_wr_a: assert property ((i_ce && i_reg_wr &&
        i_reg_addr == 8'h0C && !i_reg_wdata[2]) ##1 !i_reg_wr
        |=> o_payload_rate == $past(i_reg_wdata[2:0], 2))
        else $error("rate code not applied");
    scram_rate_a: assert property (o_scramble_on |->
        o_payload_rate == 3'h3)
        else $error("scrambler on below top rate");
    cca_energy_a: assert property ($stable(o_payload_rate) &&
        o_payload_rate inside {[3'h1:3'h3]} |-> o_cca_mode == 2'h1)
        else $error("carrier sense at high rate");
    verdict_excl_a: assert property (!(o_frame_accept &&
        o_frame_reject))
        else $error("accept and reject together");
    reject_pulse_a: assert property (o_frame_reject |=>
        !o_frame_reject [*2])
        else $error("reject pulse too long");
    ed_window_a: assert property ($rose(o_ed_busy) |->
        o_ed_busy [*7] ##[1:40] o_ed_done)
        else $error("energy window wrong");
    ack_delay_a: assert property (i_auto_ack_receive_mode &&
        i_ce && i_ack_frame_end |=> !o_ack_tx_start [*2])
        else $error("acknowledgment sent too early");
endmodule
bind hrpm_core hrpm_core_chk i_hrpm_core_chk (.*);

// *** design/hrpm_core.v ***
// High rate payload mode controller: registers, framing, ED, CCA, ack
// Summary of operation
// - Payload rate comes from three-bit field of register 0x0C.
// - Codes 0..3 mean 250, 500, 1000, 2000 kb/s; others reserved.
// - Header always runs at 250 kb/s; only payload uses chosen rate.
// - Rate choice leaves other features working, but high rate forces clear channel mode to energy only.
// - High rate buffer read gives invalid link quality byte after payload.
// - Buffer read order: state, length, payload, link quality, energy, receive status.
// - High rate energy measurement lasts 32 us, not eight symbols.
// - Nonzero threshold level drops frames weaker than threshold.
// - Each threshold step adds 3 dB; 0 most sensitive, 15 highest.
// - High rate frame with undecodable weak payload is rejected.
// - Scrambler enable resets to one, scrambling 2000 kb/s by default.
// - Writing bit 5 of 0x0C to zero stops chip scrambling.
// - High rate clear channel check uses energy threshold only.
// - Short turnaround bit cuts auto ack delay 192 us to 32 us.
// - 0x0C: protect bit 7, scrambler bit 5, rate 2:0; rest zero.
`timescale 1ns/1ps
`include "hrpm_defines.vh"
module hrpm_core #(
    parameter FIFO_DEPTH = 8,
    parameter FIFO_AW = 3,
    parameter ED_SHORT_CYC = `HRPM_ED_SHORT_CYC,
    parameter ED_STD_CYC = `HRPM_ED_STD_CYC,
    parameter ACK_STD_CYC = `HRPM_ACK_STD_CYC,
    parameter ACK_SHORT_CYC = `HRPM_ACK_SHORT_CYC
) (
    // Clock, reset, enable
    input wire i_clk,
    input wire i_nrst,
    input wire i_ce,
    // Register port
    input wire i_reg_wr,
    input wire i_reg_rd,
    input wire [7:0] i_reg_addr,
    input wire [7:0] i_reg_wdata,
    output reg [7:0] o_reg_rdata,
    // Receive side from demodulator (pins, synchronised here)
    input wire i_rx_hdr_det,
    input wire i_rx_payload_ok,
    input wire [7:0] i_rx_rssi_step,
    input wire i_rx_end,
    // Received octet stream into frame buffer
    input wire i_rx_byte_valid,
    output wire o_rx_byte_ready,
    input wire [7:0] i_rx_byte,
    // Frame buffer read port
    input wire i_fb_start,
    input wire i_fb_next,
    input wire [7:0] i_radio_state_byte,
    input wire [7:0] i_frame_len,
    input wire [7:0] i_ed_value,
    input wire [7:0] i_rx_status,
    output reg [7:0] o_fb_data,
    output wire o_fb_valid,
    // Modem control outputs
    output reg [2:0] o_payload_rate,
    output reg o_hdr_rate_std,
    output reg o_scramble_on,
    output reg o_frame_reject,
    output reg o_frame_accept,
    output reg o_rx_protect,
    // Energy detection and clear channel
    input wire i_ed_start,
    input wire [1:0] i_cca_mode_req,
    output wire o_ed_busy,
    output wire o_ed_done,
    output reg [1:0] o_cca_mode,
    // Automatic acknowledgment
    input wire i_auto_ack_receive_mode,
    input wire i_ack_frame_end,
    output wire o_ack_tx_start
);
    // ==========================================
    // Reset release
    reg rst_s1_ff;
    reg rst_s2_ff;
    wire rst_n;

    always @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rst_s1_ff <= 1'b0;
            rst_s2_ff <= 1'b0;
        end else begin
            rst_s1_ff <= 1'b1;
            rst_s2_ff <= rst_s1_ff;
        end
    end
    assign rst_n = rst_s2_ff;

    // ==========================================
    // Pin synchronisers (first stage read only by second)
    reg [2:0] pin_s1_ff;
    reg [2:0] pin_s2_ff;
    reg [7:0] rssi_s1_ff;
    reg [7:0] rssi_s2_ff;
    wire hdr_det;
    wire payload_ok;
    wire rx_end;

    always @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1_ff <= 3'h0;
            pin_s2_ff <= 3'h0;
            rssi_s1_ff <= 8'h00;
            rssi_s2_ff <= 8'h00;
        end else if (i_ce) begin
            pin_s1_ff <= {i_rx_end, i_rx_payload_ok, i_rx_hdr_det};
            pin_s2_ff <= pin_s1_ff;
            rssi_s1_ff <= i_rx_rssi_step;
            rssi_s2_ff <= rssi_s1_ff;
        end
    end
    assign hdr_det = pin_s2_ff[0];
    assign payload_ok = pin_s2_ff[1];
    assign rx_end = pin_s2_ff[2];

    // ==========================================
    // Register file
    reg [7:0] rate_ctrl_ff;
    reg [7:0] thresh_ff;
    reg [7:0] ext_ctrl_ff;
    wire [2:0] rate_sel;
    wire [3:0] thr_level;
    wire high_rate;

    // Writable bits only; reserved bits held at zero
    always @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            rate_ctrl_ff <= `HRPM_RATE_CTRL_RST;
            thresh_ff <= `HRPM_THRESH_RST;
            ext_ctrl_ff <= `HRPM_EXT_CTRL_RST;
        end else if (i_ce && i_reg_wr) begin
            case (i_reg_addr)
                `HRPM_OFS_RATE_CTRL: begin
                    rate_ctrl_ff <= i_reg_wdata & 8'hA7;
                end
                `HRPM_OFS_THRESH: begin
                    thresh_ff <= i_reg_wdata & 8'h8F;
                end
                `HRPM_OFS_EXT_CTRL: begin
                    ext_ctrl_ff <= i_reg_wdata & 8'hF7;
                end
                default: begin
                end
            endcase
        end
    end

    // Read mux; unmapped offsets read zero
    always @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_reg_rdata <= 8'h00;
        end else if (i_ce && i_reg_rd) begin
            case (i_reg_addr)
                `HRPM_OFS_RATE_CTRL: o_reg_rdata <= rate_ctrl_ff;
                `HRPM_OFS_THRESH: o_reg_rdata <= thresh_ff;
                `HRPM_OFS_EXT_CTRL: o_reg_rdata <= ext_ctrl_ff;
                default: o_reg_rdata <= 8'h00;
            endcase
        end
    end

    assign rate_sel = rate_ctrl_ff[`HRPM_RATE_HI:`HRPM_RATE_LO];
    assign thr_level = thresh_ff[`HRPM_THR_HI:`HRPM_THR_LO];
    // Reserved rate codes fall back to the standard rate
    assign high_rate = (rate_sel == `HRPM_RATE_500) |
                       (rate_sel == `HRPM_RATE_1000) |
                       (rate_sel == `HRPM_RATE_2000);

    // ==========================================
    // Modem rate and scrambler steering
    // Rate changes payload timing and gates the scrambler; header and protect paths stay untouched
    always @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_payload_rate <= `HRPM_RATE_250;
            o_hdr_rate_std <= 1'b1;
            o_scramble_on <= 1'b0;
            o_rx_protect <= 1'b0;
        end else if (i_ce) begin
            o_payload_rate <= high_rate ? rate_sel : `HRPM_RATE_250;
            o_hdr_rate_std <= 1'b1;
            o_scramble_on <= (rate_sel == `HRPM_RATE_2000) &
                             rate_ctrl_ff[`HRPM_BIT_SCRAM];
            o_rx_protect <= rate_ctrl_ff[`HRPM_BIT_RX_PROTECT];
        end
    end

    // ==========================================
    // Frame acceptance on header detect
    // Level compare in 3 dB steps; level 0 lets everything through
    reg in_frame_ff;
    wire below_thr;
    assign below_thr = (thr_level != 4'h0) &&
                       (rssi_s2_ff < {4'h0, thr_level});

    always @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            in_frame_ff <= 1'b0;
            o_frame_reject <= 1'b0;
            o_frame_accept <= 1'b0;
        end else if (i_ce) begin
            o_frame_reject <= 1'b0;
            o_frame_accept <= 1'b0;
            if (!in_frame_ff && hdr_det) begin
                in_frame_ff <= 1'b1;
                if (below_thr) begin
                    o_frame_reject <= 1'b1;
                end else if (high_rate && !payload_ok) begin
                    o_frame_reject <= 1'b1;
                end else begin
                    o_frame_accept <= 1'b1;
                end
            end else if (in_frame_ff && rx_end) begin
                in_frame_ff <= 1'b0;
            end
        end
    end

    // ==========================================
    // Payload buffering in an 8-entry FIFO
    wire pl_valid;
    wire [7:0] pl_data;
    wire pl_pop;
    wire fb_flush;

    hrpm_fifo #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH),
        .AW(FIFO_AW)
    ) u_fifo (
        .i_clk(i_clk),
        .i_rst_n(rst_n),
        .i_ce(i_ce),
        .i_in_valid(i_rx_byte_valid),
        .o_in_ready(o_rx_byte_ready),
        .i_in_data(i_rx_byte),
        .o_out_valid(pl_valid),
        .i_out_ready(pl_pop),
        .o_out_data(pl_data),
        .i_flush(fb_flush)
    );

    // ==========================================
    // Frame buffer read sequencer
    localparam FB_IDLE = 3'd0;
    localparam FB_STATE = 3'd1;
    localparam FB_LEN = 3'd2;
    localparam FB_PAYLOAD = 3'd3;
    localparam FB_LQI = 3'd4;
    localparam FB_ED = 3'd5;
    localparam FB_STATUS = 3'd6;

    reg [2:0] fb_st_ff;
    reg [2:0] nxt_fb_st;
    reg [7:0] fb_left_ff;
    reg [7:0] nxt_fb_left;
    reg [7:0] nxt_fb_data;

    assign fb_flush = i_fb_start;
    // Stall payload phase while the FIFO is empty
    assign pl_pop = (fb_st_ff == FB_LEN || fb_st_ff == FB_PAYLOAD) &&
                    i_fb_next && (fb_left_ff != 8'h00) && pl_valid;
    assign o_fb_valid = (fb_st_ff != FB_IDLE) &&
                        !((fb_st_ff == FB_PAYLOAD) && !pl_valid &&
                          (fb_left_ff != 8'h00));

    // Ordering: state, length, payload, link quality, energy, status
    always @* begin
        nxt_fb_st = fb_st_ff;
        nxt_fb_left = fb_left_ff;
        nxt_fb_data = o_fb_data;
        if (i_fb_start) begin
            nxt_fb_st = FB_STATE;
            nxt_fb_data = i_radio_state_byte;
        end else if (i_fb_next) begin
            case (fb_st_ff)
                FB_STATE: begin
                    nxt_fb_st = FB_LEN;
                    nxt_fb_left = i_frame_len;
                    nxt_fb_data = i_frame_len;
                end
                FB_LEN, FB_PAYLOAD: begin
                    if (fb_left_ff == 8'h00) begin
                        nxt_fb_st = FB_LQI;
                        nxt_fb_data = 8'h00;
                    end else if (pl_valid) begin
                        nxt_fb_st = FB_PAYLOAD;
                        nxt_fb_left = fb_left_ff - 8'h01;
                        nxt_fb_data = pl_data;
                    end
                end
                FB_LQI: begin
                    nxt_fb_st = FB_ED;
                    nxt_fb_data = i_ed_value;
                end
                FB_ED: begin
                    nxt_fb_st = FB_STATUS;
                    nxt_fb_data = i_rx_status;
                end
                FB_STATUS: begin
                    nxt_fb_st = FB_IDLE;
                    nxt_fb_data = 8'h00;
                end
                default: begin
                    nxt_fb_st = FB_IDLE;
                end
            endcase
        end
    end

    // Pop happens on the step out of the length stage too
    always @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            fb_st_ff <= FB_IDLE;
            fb_left_ff <= 8'h00;
            o_fb_data <= 8'h00;
        end else if (i_ce) begin
            fb_st_ff <= nxt_fb_st;
            fb_left_ff <= nxt_fb_left;
            o_fb_data <= nxt_fb_data;
        end
    end

    // ==========================================
    // Energy detection window
    wire [`HRPM_TMR_W-1:0] ed_len;
    assign ed_len = high_rate ? ED_SHORT_CYC[`HRPM_TMR_W-1:0] :
                                ED_STD_CYC[`HRPM_TMR_W-1:0];

    hrpm_timer #(
        .W(`HRPM_TMR_W)
    ) u_ed_tmr (
        .i_clk(i_clk),
        .i_rst_n(rst_n),
        .i_ce(i_ce),
        .i_start(i_ed_start),
        .i_len(ed_len),
        .o_busy(o_ed_busy),
        .o_done(o_ed_done)
    );

    // Carrier sense modes are forced to energy only at high rate
    always @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_cca_mode <= 2'h1;
        end else if (i_ce) begin
            o_cca_mode <= high_rate ? 2'h1 : i_cca_mode_req;
        end
    end

    // ==========================================
    // Acknowledgment turnaround
    wire [`HRPM_TMR_W-1:0] ack_len;
    wire ack_go;
    assign ack_len = ext_ctrl_ff[`HRPM_BIT_SHORT_ACK] ?
                     ACK_SHORT_CYC[`HRPM_TMR_W-1:0] :
                     ACK_STD_CYC[`HRPM_TMR_W-1:0];
    assign ack_go = i_auto_ack_receive_mode & i_ack_frame_end;

    hrpm_timer #(
        .W(`HRPM_TMR_W)
    ) u_ack_tmr (
        .i_clk(i_clk),
        .i_rst_n(rst_n),
        .i_ce(i_ce),
        .i_start(ack_go),
        .i_len(ack_len),
        .o_busy(),
        .o_done(o_ack_tx_start)
    );
endmodule

// *** design/hrpm_defines.vh ***
// Constants of the high rate payload mode controller
`ifndef HRPM_DEFINES_VH
`define HRPM_DEFINES_VH
// Register offsets
`define HRPM_OFS_RATE_CTRL 8'h0C
`define HRPM_OFS_THRESH 8'h15
`define HRPM_OFS_EXT_CTRL 8'h17
// Rate control fields and reset value
`define HRPM_BIT_RX_PROTECT 7
`define HRPM_BIT_SCRAM 5
`define HRPM_RATE_HI 2
`define HRPM_RATE_LO 0
`define HRPM_RATE_CTRL_RST 8'h20
// Threshold and extended control fields
`define HRPM_THR_HI 3
`define HRPM_THR_LO 0
`define HRPM_BIT_SHORT_ACK 2
`define HRPM_THRESH_RST 8'h00
`define HRPM_EXT_CTRL_RST 8'h00
// Rate codes
`define HRPM_RATE_250 3'h0
`define HRPM_RATE_500 3'h1
`define HRPM_RATE_1000 3'h2
`define HRPM_RATE_2000 3'h3
// Timing counts in 40 ns clock cycles
`define HRPM_ED_SHORT_CYC 800
`define HRPM_ED_STD_CYC 3200
`define HRPM_ACK_STD_CYC 4800
`define HRPM_ACK_SHORT_CYC 800
`define HRPM_TMR_W 13
`endif

// *** design/hrpm_fifo.v ***
// Parameterised flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
module hrpm_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    // Clock, reset, enable
    input wire i_clk,
    input wire i_rst_n,
    input wire i_ce,
    // Fill side
    input wire i_in_valid,
    output wire o_in_ready,
    input wire [WIDTH-1:0] i_in_data,
    // Drain side
    output wire o_out_valid,
    input wire i_out_ready,
    output wire [WIDTH-1:0] o_out_data,
    // Flush
    input wire i_flush
);
    reg [WIDTH-1:0] mem_ff [0:DEPTH-1];
    reg [AW-1:0] wr_ff;
    reg [AW-1:0] rd_ff;
    reg [AW:0] cnt_ff;
    wire push;
    wire pop;
    integer k;

    // Honest full and empty from the occupancy count
    assign o_in_ready = (cnt_ff != DEPTH[AW:0]);
    assign o_out_valid = (cnt_ff != {(AW+1){1'b0}});
    assign o_out_data = mem_ff[rd_ff];
    assign push = i_in_valid & o_in_ready;
    assign pop = o_out_valid & i_out_ready;

    // ==========================================
    // Pointers and storage
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wr_ff <= {AW{1'b0}};
            rd_ff <= {AW{1'b0}};
            cnt_ff <= {(AW+1){1'b0}};
            for (k = 0; k < DEPTH; k = k + 1) begin
                mem_ff[k] <= {WIDTH{1'b0}};
            end
        end else if (i_ce) begin
            if (i_flush) begin
                wr_ff <= {AW{1'b0}};
                rd_ff <= {AW{1'b0}};
                cnt_ff <= {(AW+1){1'b0}};
            end else begin
                if (push) begin
                    mem_ff[wr_ff] <= i_in_data;
                    wr_ff <= wr_ff + 1'b1;
                end
                if (pop) begin
                    rd_ff <= rd_ff + 1'b1;
                end
                if (push & ~pop) begin
                    cnt_ff <= cnt_ff + 1'b1;
                end else if (pop & ~push) begin
                    cnt_ff <= cnt_ff - 1'b1;
                end
            end
        end
    end
endmodule

// *** design/hrpm_timer.v ***
// Down counter for measurement and turnaround windows
`timescale 1ns/1ps
module hrpm_timer #(
    parameter W = 13
) (
    // Clock, reset, enable
    input wire i_clk,
    input wire i_rst_n,
    input wire i_ce,
    // Control
    input wire i_start,
    input wire [W-1:0] i_len,
    // Status
    output wire o_busy,
    output reg o_done
);
    reg [W-1:0] cnt_ff;

    assign o_busy = (cnt_ff != {W{1'b0}});

    // ==========================================
    // Load on start, pulse done when reaching zero
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_ff <= {W{1'b0}};
            o_done <= 1'b0;
        end else if (i_ce) begin
            o_done <= (cnt_ff == {{(W-1){1'b0}}, 1'b1});
            if (i_start) begin
                cnt_ff <= i_len;
            end else if (o_busy) begin
                cnt_ff <= cnt_ff - 1'b1;
            end
        end
    end
endmodule
